// ===== logic/pbc_cfg.svh
// constants for the basic control register block
// assumes 10 MHz ref_clk_i and a 5-bit register address
`ifndef PBC_CFG_SVH
`define PBC_CFG_SVH

// -----------------------------------------------------------------
// register map
// -----------------------------------------------------------------
`define PBC_ADDR_W      5
`define PBC_OFS_BMC     5'h00
`define PBC_OFS_STAT    5'h1F

// -----------------------------------------------------------------
// basic control field positions
// -----------------------------------------------------------------
`define PBC_B_SRST      15
`define PBC_B_LOOP      14
`define PBC_B_SPEED     13
`define PBC_B_ANEN      12
`define PBC_B_PD        11
`define PBC_B_ISO       10
`define PBC_B_RESTART   9
`define PBC_B_DUPLEX    8
`define PBC_B_COLTEST   7
`define PBC_RSV_W       7
`define PBC_RSV_VAL     7'h00

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define PBC_CLK_NS      100
`define PBC_BIT_NS      100
`define PBC_COL_ON_BITS 512
`define PBC_COL_OFF_BIT 4
`define PBC_COL_ON_CYC  ((`PBC_COL_ON_BITS * `PBC_BIT_NS) / `PBC_CLK_NS)
`define PBC_COL_OFF_CYC ((`PBC_COL_OFF_BIT * `PBC_BIT_NS) / `PBC_CLK_NS)
`define PBC_SRST_W      4
`define PBC_SRST_CYC    4'hF
`define PBC_CNT_ZERO    4'h0
`define PBC_CNT_ONE     4'h1

`endif

// ===== logic/pbc_ctrl.sv
// basic mode control register, low half plus its dependencies
// assumes a single-cycle register port and an external
// auto-negotiation engine that acknowledges a restart request
//
// Operation
// - power-down stops everything except the register block
// - effective power-down is register bit OR the pin
// - pin driven low sets the power-down bit
// - isolate detaches the MII; register access keeps working
// - writing one to restart bit relaunches auto-negotiation
// - restart request ignored while auto-negotiation enable is zero
// - restart bit reads one until negotiation starts, then clears
// - clearing restart bit does not disturb running negotiation
// - duplex bit picks full or half duplex; reset from strap
// - collision test raises COL within 512 bit times of TX_EN
// - collision test drops COL within 4 bit times of TX_EN fall
// - reserved bits 6:0 ignore writes and read zero
// - with auto-negotiation on, speed and duplex bits are ignored
// - software reset bit reloads straps and self-clears when done
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "pbc_cfg.svh"

module pbc_ctrl (
    input  wire logic                ref_clk_i,
    input  wire logic                rst_i,
    input  wire pbc_pkg::pbc_bus_req_t bus_i,
    output logic [15:0]              rdata_o,
    input  wire logic                powerdown_irq_pin_n_i,
    input  wire pbc_pkg::pbc_strap_t strap_i,
    input  wire logic                tx_en_i,
    output logic                     col_o,
    input  wire logic                an_initiated_i,
    output logic                     an_restart_o,
    output logic                     an_enable_o,
    output logic                     manual_mode_o,
    output logic                     speed_100_o,
    output logic                     full_duplex_o,
    output logic                     loopback_o,
    output logic                     powerdown_o,
    output logic                     isolate_o,
    output logic                     soft_reset_o
);
    import pbc_pkg::*;

    pbc_state_t s_q;
    pbc_state_t s_d;
    logic       pin_low;
    logic       eff_pd;
    logic       bmc_wr;
    logic [15:0] bmc_rd;
    logic [15:0] stat_rd;

    // -------------------------------------------------------------
    // decoded views
    // -------------------------------------------------------------
    // pin is read only after its second flop
    assign pin_low = ~s_q.pin_s[1];
    assign eff_pd  = s_q.pd | pin_low;
    // writes during a software reset are dropped, not queued
    assign bmc_wr  = bus_i.we & (bus_i.addr == `PBC_OFS_BMC) & ~s_q.srst;

    // readback image; reserved field is a constant zero
    always_comb begin
        bmc_rd = {s_q.srst, s_q.loopback, s_q.speed, s_q.an_en,
                  s_q.pd, s_q.iso, s_q.restart, s_q.duplex,
                  s_q.coltest, `PBC_RSV_VAL};
    end

    // own status word: live conditions for software
    always_comb begin
        stat_rd = 16'h0000;
        stat_rd[4] = eff_pd;
        stat_rd[3] = isolate_o;
        stat_rd[2] = an_restart_o;
        stat_rd[1] = s_q.col;
        stat_rd[0] = s_q.tx_s[1];
    end

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // two-flop synchronisers for pins
        s_d.pin_s    = {s_q.pin_s[0], powerdown_irq_pin_n_i};
        s_d.tx_s     = {s_q.tx_s[0], tx_en_i};
        s_d.strap_s0 = strap_i;
        s_d.strap_s1 = s_q.strap_s0;
        s_d.load     = 1'b0;

        // collision test loops TX_EN straight back, 3 cycles total
        s_d.col = s_q.coltest & s_q.tx_s[1]
                  & ~eff_pd & ~s_q.iso;

        // engine took the request: self-clear
        if (s_q.restart && an_initiated_i) begin
            s_d.restart = 1'b0;
        end

        // software write; set beats the engine's clear above
        if (bmc_wr) begin
            s_d.loopback = bus_i.wdata[`PBC_B_LOOP];
            s_d.speed    = bus_i.wdata[`PBC_B_SPEED];
            s_d.an_en    = bus_i.wdata[`PBC_B_ANEN];
            s_d.pd       = bus_i.wdata[`PBC_B_PD];
            s_d.iso      = bus_i.wdata[`PBC_B_ISO];
            s_d.duplex   = bus_i.wdata[`PBC_B_DUPLEX];
            s_d.coltest  = bus_i.wdata[`PBC_B_COLTEST];
            if (bus_i.wdata[`PBC_B_RESTART] &&
                bus_i.wdata[`PBC_B_ANEN]) begin
                s_d.restart = 1'b1;
            end else begin
                // the bit and an_restart_o drop; a launched engine keeps going
                s_d.restart = 1'b0;
            end
            if (bus_i.wdata[`PBC_B_SRST]) begin
                s_d.srst     = 1'b1;
                s_d.srst_cnt = `PBC_SRST_CYC;
            end
        end

        // software reset countdown, then defaults and re-strap
        if (s_q.srst) begin
            if (s_q.srst_cnt == `PBC_CNT_ZERO) begin
                s_d.srst     = 1'b0;
                s_d.loopback = 1'b0;
                s_d.pd       = 1'b0;
                s_d.iso      = 1'b0;
                s_d.restart  = 1'b0;
                s_d.coltest  = 1'b0;
                s_d.load     = 1'b1;
            end else begin
                s_d.srst_cnt = s_q.srst_cnt - `PBC_CNT_ONE;
            end
        end

        // straps are taken from the synchronised copy
        if (s_q.load) begin
            s_d.an_en  = s_q.strap_s1.an_en;
            s_d.speed  = s_q.strap_s1.speed;
            s_d.duplex = s_q.strap_s1.duplex;
        end

        // pin has the last word over any write
        if (pin_low) begin
            s_d.pd = 1'b1;
        end

        // registered read port, unmapped reads give zero
        s_d.rdata = 16'h0000;
        if (bus_i.re && bus_i.addr == `PBC_OFS_BMC) begin
            s_d.rdata = bmc_rd;
        end else if (bus_i.re && bus_i.addr == `PBC_OFS_STAT) begin
            s_d.rdata = stat_rd;
        end

        // synchronous reset; straps loaded the cycle after release
        if (rst_i) begin
            s_d          = '0;
            s_d.pin_s    = 2'b11;
            s_d.load     = 1'b1;
            // strap sync keeps running, else the load would take zeros
            s_d.strap_s0 = strap_i;
            s_d.strap_s1 = s_q.strap_s0;
        end
    end

    // -------------------------------------------------------------
    // state register
    // -------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        s_q <= s_d;
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    // power-down forces isolate and silences restart, loopback and COL; speed and duplex pass through
    assign powerdown_o   = eff_pd;
    assign isolate_o     = s_q.iso | eff_pd;
    assign an_restart_o  = s_q.restart & s_q.an_en
                           & ~eff_pd;
    assign an_enable_o   = s_q.an_en;
    // datapath uses speed and duplex only in manual mode
    assign manual_mode_o = ~s_q.an_en & ~s_q.srst;
    assign speed_100_o   = s_q.speed;
    assign full_duplex_o = s_q.duplex;
    assign loopback_o    = s_q.loopback & ~eff_pd;
    assign soft_reset_o  = s_q.srst;
    assign col_o         = s_q.col;
    assign rdata_o       = s_q.rdata;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    localparam int SRST_MAX = 20;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    property p_pd_pin;
        pin_low |=> s_q.pd && powerdown_o;
    endproperty
    a_pd_pin: assert property (p_pd_pin)
        else $error("pin low did not set power-down");

    property p_pd_or;
        pin_low && !s_q.pd |-> powerdown_o;
    endproperty
    a_pd_or: assert property (p_pd_or)
        else $error("pin low not reflected in power-down");

    // col_o is registered, so it answers one cycle later
    property p_pd_shut;
        powerdown_o |-> !an_restart_o && isolate_o ##1 !col_o;
    endproperty
    a_pd_shut: assert property (p_pd_shut)
        else $error("datapath active during power-down");

    property p_iso;
        s_q.iso |-> isolate_o ##1 !col_o;
    endproperty
    a_iso: assert property (p_iso)
        else $error("isolate did not detach the port");

    property p_restart_set;
        bmc_wr && bus_i.wdata[`PBC_B_ANEN]
        && bus_i.wdata[`PBC_B_RESTART] |=> s_q.restart;
    endproperty
    a_restart_set: assert property (p_restart_set)
        else $error("restart write not latched");

    property p_restart_ign;
        bmc_wr && !bus_i.wdata[`PBC_B_ANEN] |=> !s_q.restart;
    endproperty
    a_restart_ign: assert property (p_restart_ign)
        else $error("restart taken with auto-negotiation off");

    property p_restart_hold;
        s_q.restart && !an_initiated_i && !bus_i.we && !s_q.srst
        |=> s_q.restart;
    endproperty
    a_restart_hold: assert property (p_restart_hold)
        else $error("restart cleared before initiation");

    property p_restart_clr;
        s_q.restart && an_initiated_i && !bmc_wr |=> !s_q.restart;
    endproperty
    a_restart_clr: assert property (p_restart_clr)
        else $error("restart did not self-clear");

    property p_restart_drop;
        bmc_wr && !bus_i.wdata[`PBC_B_RESTART] |=> !an_restart_o;
    endproperty
    a_restart_drop: assert property (p_restart_drop)
        else $error("restart request kept after a write of zero");

    property p_duplex;
        bmc_wr |=> full_duplex_o == $past(bus_i.wdata[`PBC_B_DUPLEX]);
    endproperty
    a_duplex: assert property (p_duplex)
        else $error("duplex write lost");

    property p_col_on;
        s_q.coltest && !eff_pd && !s_q.iso && $rose(s_q.tx_s[1])
        |=> col_o;
    endproperty
    a_col_on: assert property (p_col_on)
        else $error("collision test did not raise COL");

    property p_col_idle;
        !s_q.coltest |=> !col_o;
    endproperty
    a_col_idle: assert property (p_col_idle)
        else $error("COL raised without collision test");

    property p_col_off;
        $fell(tx_en_i) ##1 !tx_en_i[*3] |-> !col_o;
    endproperty
    a_col_off: assert property (p_col_off)
        else $error("COL held past four bit times");

    property p_rsv;
        bus_i.re |=> rdata_o[`PBC_RSV_W-1:0] == `PBC_RSV_VAL
                     || $past(bus_i.addr) != `PBC_OFS_BMC;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved bits read non-zero");

    property p_manual;
        s_q.an_en |-> !manual_mode_o;
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual mode while auto-negotiating");

    property p_srst;
        bmc_wr && bus_i.wdata[`PBC_B_SRST]
        |=> soft_reset_o ##[1:SRST_MAX] !soft_reset_o;
    endproperty
    a_srst: assert property (p_srst)
        else $error("software reset did not complete");

    c_restart: cover property (s_q.restart ##1 !s_q.restart);
    c_col: cover property ($rose(col_o));
    c_srst: cover property ($fell(soft_reset_o));
    c_pin: cover property ($rose(pin_low));
    c_iso: cover property ($rose(isolate_o));

endmodule

// ===== logic/pbc_pkg.sv
// types shared by the basic control register block
// assumes pbc_cfg.svh is on the include path
`include "pbc_cfg.svh"

package pbc_pkg;

    // -------------------------------------------------------------
    // register port request
    // -------------------------------------------------------------
    typedef struct packed {
        logic [`PBC_ADDR_W-1:0] addr;
        logic [15:0]            wdata;
        logic                   we;
        logic                   re;
    } pbc_bus_req_t;

    // -------------------------------------------------------------
    // strapped configuration: an_en, speed, duplex
    // -------------------------------------------------------------
    typedef struct packed {
        logic an_en;
        logic speed;
        logic duplex;
    } pbc_strap_t;

    // -------------------------------------------------------------
    // whole module state
    // -------------------------------------------------------------
    typedef struct packed {
        logic                   srst;
        logic [`PBC_SRST_W-1:0] srst_cnt;
        logic                   loopback;
        logic                   speed;
        logic                   an_en;
        logic                   pd;
        logic                   iso;
        logic                   restart;
        logic                   duplex;
        logic                   coltest;
        logic                   load;
        logic [1:0]             pin_s;
        logic [1:0]             tx_s;
        pbc_strap_t             strap_s0;
        pbc_strap_t             strap_s1;
        logic                   col;
        logic [15:0]            rdata;
    } pbc_state_t;

endpackage

// ===== verif/pbc_an_model.sv
// behavioural auto-negotiation engine answering the restart request
// assumes the control block's clock and synchronous active-high reset
`timescale 1ns/1ps

module pbc_an_model (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       restart_i,
    input  wire logic [3:0] delay_i,
    output logic            initiated_o
);
    logic       busy_q;
    logic [3:0] cnt_q;

    // -------------------------------------------------------------
    // negotiation launch
    // -------------------------------------------------------------
    // once launched a negotiation runs to its end, so software clearing
    // the request later cannot cut it short; the ack cycle blocks a relaunch
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            initiated_o <= 1'b0;
        end else if (busy_q) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == delay_i) begin
                busy_q <= 1'b0;
                initiated_o <= 1'b1;
            end
        end else begin
            initiated_o <= 1'b0;
            if (restart_i && !initiated_o) begin
                busy_q <= 1'b1;
                cnt_q <= 4'h0;
            end
        end
    end
endmodule

// ===== verif/phy_basic_control_low_bits_test.sv
// self-checking bench for the basic control register block
// assumes the design files and pbc_an_model.sv are compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module phy_basic_control_low_bits_test;
    import pbc_pkg::*;

    logic         ref_clk_i;
    logic         rst_i = 1'b1;
    pbc_bus_req_t bus = '0;
    pbc_strap_t   strap = '0;
    logic         pin_n = 1'b1;
    logic         tx_en = 1'b0;
    logic [3:0]   an_dly = 4'h0;
    logic [15:0]  rdata, d, w;
    logic         an_init, an_restart, an_enable, manual, speed, fdx;
    logic         loopb, pd, iso, srst, col;
    int           n, bad_count = 0, compares = 0, ticks = 0;

    pbc_ctrl uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_i(bus),
        .rdata_o(rdata), .powerdown_irq_pin_n_i(pin_n), .strap_i(strap),
        .tx_en_i(tx_en), .col_o(col), .an_initiated_i(an_init),
        .an_restart_o(an_restart), .an_enable_o(an_enable),
        .manual_mode_o(manual), .speed_100_o(speed),
        .full_duplex_o(fdx), .loopback_o(loopb), .powerdown_o(pd),
        .isolate_o(iso), .soft_reset_o(srst));

    pbc_an_model an_peer (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .restart_i(an_restart), .delay_i(an_dly), .initiated_o(an_init));

    // -------------------------------------------------------------
    // clock, run limit, helpers
    // -------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // a hung wait ends the run instead of spinning forever
    always @(posedge ref_clk_i) begin
        ticks++;
        if (ticks == 3000) begin
            bad_count++;
            print_verdict();
        end
    end

    task print_verdict();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // sample 1 ns past the edge so the design's updates have landed
    task idle(input int k);
        repeat (k) @(posedge ref_clk_i);
        #1;
    endtask

    task wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge ref_clk_i);
        bus.we <= 1'b1;
        bus.addr <= a;
        bus.wdata <= v;
        @(posedge ref_clk_i);
        bus.we <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge ref_clk_i);
        bus.re <= 1'b1;
        bus.addr <= a;
        @(posedge ref_clk_i);
        bus.re <= 1'b0;
        #1;
        v = rdata;
    endtask

    function automatic logic [15:0] exp_reset();
        return {2'b00, strap.speed, strap.an_en, 3'b000, strap.duplex, 8'h00};
    endfunction

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        void'($urandom(51100));
        strap = 3'($urandom);
        an_dly = 4'($urandom_range(9, 0));
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        idle(3);
        rd(5'h00, d);
        `CHK(d, exp_reset())
        rd(5'h05, d);
        `CHK(d, 16'h0000)
        // random words; self-clearing and power-down bits kept out
        repeat (12) begin
            w = 16'($urandom) & 16'h75FF;
            wr(5'h00, w);
            `CHK(manual, ~w[12])
            if (!w[12]) `CHK({speed, fdx}, {w[13], w[8]})
            rd(5'h00, d);
            `CHK(d, w & 16'h7580)
        end
        // restart ignored with negotiation off
        wr(5'h00, 16'h0200);
        `CHK(an_restart, 1'b0)
        rd(5'h00, d);
        `CHK(d[9], 1'b0)
        // restart launched, reads one until acknowledged
        wr(5'h00, 16'h1200);
        `CHK(an_restart, 1'b1)
        rd(5'h00, d);
        `CHK(d[9], 1'b1)
        n = 0;
        while (an_restart !== 1'b0 && n < 20) begin
            idle(1);
            n++;
        end
        rd(5'h00, d);
        `CHK({n < 20, d[9]}, 2'b10)
        // software clears the request mid-flight
        wr(5'h00, 16'h1200);
        wr(5'h00, 16'h1000);
        `CHK({an_restart, an_enable}, 2'b01)
        // collision test follows transmit enable
        wr(5'h00, 16'h0080);
        @(posedge ref_clk_i);
        tx_en <= 1'b1;
        n = 0;
        while (col !== 1'b1 && n < 600) begin
            idle(1);
            n++;
        end
        `CHK(n <= 512, 1'b1)
        @(posedge ref_clk_i);
        tx_en <= 1'b0;
        n = 0;
        while (col !== 1'b0 && n < 10) begin
            idle(1);
            n++;
        end
        `CHK(n <= 4, 1'b1)
        wr(5'h00, 16'h0000);
        @(posedge ref_clk_i);
        tx_en <= 1'b1;
        idle(8);
        `CHK(col, 1'b0)
        @(posedge ref_clk_i);
        tx_en <= 1'b0;
        // isolate leaves register access working
        wr(5'h00, 16'h0400);
        rd(5'h00, d);
        `CHK({iso, d}, {1'b1, 16'h0400})
        wr(5'h00, 16'h0000);
        `CHK(iso, 1'b0)
        // power-down by register, then by the pin
        wr(5'h00, 16'h4880);
        `CHK({pd, loopb, iso}, 3'b101)
        wr(5'h00, 16'h0000);
        @(posedge ref_clk_i);
        pin_n <= 1'b0;
        idle(4);
        `CHK(pd, 1'b1)
        // status word: power-down and isolate live, nothing else
        rd(5'h1F, d);
        `CHK(d, 16'h0018)
        wr(5'h00, 16'h0000);
        rd(5'h00, d);
        `CHK(d[11], 1'b1)
        @(posedge ref_clk_i);
        pin_n <= 1'b1;
        idle(4);
        wr(5'h00, 16'h0000);
        `CHK(pd, 1'b0)
        // software reset clears controls and reloads straps
        wr(5'h00, 16'hC480);
        rd(5'h00, d);
        `CHK({srst, d[15]}, 2'b11)
        n = 0;
        while (srst !== 1'b0 && n < 40) begin
            idle(1);
            n++;
        end
        idle(3);
        rd(5'h00, d);
        `CHK({n < 40, d}, {1'b1, exp_reset()})
        // mid-run reset drops the controls and re-takes the straps
        wr(5'h00, 16'h0480);
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        idle(3);
        rd(5'h00, d);
        `CHK(d, exp_reset())
        print_verdict();
    end
endmodule
